/* rtl/cais_top.sv */
/*
  Alarm status and change-of-status block for fourteen line
  channels, with register port, global enables and interrupt.
  Assumes alarm inputs synchronous to clk_in and a register
  master that never issues read and write together.
*/
// Design decision made here: the address-and-strobe port.
//
// Summary of operation
// R1: d6 shows transmit driver failure live
// R2: d5 shows fifo pointers within three bits
// R3: d4 shows violation activity by default
// R4: global mode bit makes d4 show overflow
// R5: d2 shows all-ones signal detected
// R6: d1 shows receive loss of signal
// R7: d0 shows test pattern detector lock
// R8: alarm bits track regardless of enables
// R9: interrupt needs channel and global enable
// R10: d6 d5 d4 d2 latch any change
// R11: reserved d7 d3 read zero
// R12: d1 d0 latch loss and pattern changes
// R13: reading change register clears its bits
// R14: enabled latched change raises interrupt
// R15: each channel at base plus sixteen times
// R16: interrupt holds until enabled changes cleared
`timescale 1ns/1ps
module cais_top (
  input wire logic clk_in, // 100 MHz system clock
  input wire logic sys_rst_in, // sync reset, active high
  input wire logic ce_in, // clock enable, freezes all state
  input wire logic [7:0] addr_in, // register byte address
  input wire logic [7:0] wr_data_in, // register write data
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  input wire logic [cais_pkg::NUM_CH-1:0] driver_fault_alarm_in, // tx fail
  input wire logic [cais_pkg::NUM_CH-1:0] fifo_pointer_near_alarm_in, // fifo
  input wire logic [cais_pkg::NUM_CH-1:0] violation_in, // violation seen
  input wire logic [cais_pkg::NUM_CH-1:0] overflow_in, // counter overflow
  input wire logic [cais_pkg::NUM_CH-1:0] all_ones_alarm_in, // all ones
  input wire logic [cais_pkg::NUM_CH-1:0] receive_signal_lost_in, // los
  input wire logic [cais_pkg::NUM_CH-1:0] test_pattern_locked_in, // lock
  output logic [7:0] rd_data_out, // read data, cycle after strobe
  output logic irq_out // interrupt, active high level
);
  logic [3:0] ch_field;
  logic [3:0] sub_field;
  logic ch_hit;
  logic wr_ok;
  logic rd_ok;
  logic global_irq_enable;
  logic viol_mode;
  logic [7:0] alarm_state [cais_pkg::NUM_CH];
  logic [7:0] change_latch [cais_pkg::NUM_CH];
  logic [7:0] enable_reg [cais_pkg::NUM_CH];
  logic [cais_pkg::NUM_CH-1:0] ch_req;
  logic [cais_pkg::NUM_CH-1:0] pend;
  logic [cais_pkg::NUM_CH-1:0] mask;
  logic [cais_pkg::NUM_CH-1:0] pend_clr;
  logic mask_lo_wr;
  logic mask_hi_wr;
  logic [7:0] next_rd_data;

  // channel number in the high nibble, register in the low [R15]
  assign ch_field = addr_in[7:4];
  assign sub_field = addr_in[3:0];
  assign ch_hit = (ch_field <= cais_pkg::CH_FIELD_MAX);
  assign wr_ok = ce_in & wr_in;
  assign rd_ok = ce_in & rd_in;

  assign mask_lo_wr = wr_ok & (addr_in == cais_pkg::ADDR_MASK_LO);
  assign mask_hi_wr = wr_ok & (addr_in == cais_pkg::ADDR_MASK_HI);
  assign pend_clr[cais_pkg::LO_CH-1:0] =
    (wr_ok & (addr_in == cais_pkg::ADDR_PEND_LO)) ?
    wr_data_in : cais_pkg::RST_REG8;
  assign pend_clr[cais_pkg::NUM_CH-1:cais_pkg::LO_CH] =
    (wr_ok & (addr_in == cais_pkg::ADDR_PEND_HI)) ?
    wr_data_in[cais_pkg::HI_CH-1:0] :
    cais_pkg::RST_REG8[cais_pkg::HI_CH-1:0];

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      global_irq_enable <= 1'b0;
    end else if (wr_ok && addr_in == cais_pkg::ADDR_GLOBAL_IRQ) begin
      global_irq_enable <= wr_data_in[cais_pkg::GIE_BIT];
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      viol_mode <= 1'b0;
    end else if (wr_ok && addr_in == cais_pkg::ADDR_VIOL_MODE) begin
      viol_mode <= wr_data_in[cais_pkg::VIOL_MODE_BIT]; // [R4]
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < cais_pkg::NUM_CH; gi++) begin : g_ch
      logic ch_sel;
      assign ch_sel = (ch_field == 4'(gi)); // [R15]
      cais_channel u_channel (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .ce_in(ce_in),
        .driver_fault_alarm_in(driver_fault_alarm_in[gi]),
        .fifo_pointer_near_alarm_in(fifo_pointer_near_alarm_in[gi]),
        .violation_in(violation_in[gi]),
        .overflow_in(overflow_in[gi]),
        .all_ones_alarm_in(all_ones_alarm_in[gi]),
        .receive_signal_lost_in(receive_signal_lost_in[gi]),
        .test_pattern_locked_in(test_pattern_locked_in[gi]),
        .overflow_mode_in(viol_mode),
        .enable_wr_in(wr_ok & ch_sel &
                      (sub_field == cais_pkg::OFF_ENABLE)),
        .wr_data_in(wr_data_in),
        .change_rd_in(rd_ok & ch_sel &
                      (sub_field == cais_pkg::OFF_CHANGE)), // [R13]
        .alarm_state_out(alarm_state[gi]),
        .change_latch_out(change_latch[gi]),
        .enable_out(enable_reg[gi]),
        .req_out(ch_req[gi])
      );
    end
  endgenerate

  cais_irq u_irq (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .ch_req_in(ch_req),
    .global_irq_enable_in(global_irq_enable),
    .pend_clr_in(pend_clr),
    .mask_lo_wr_in(mask_lo_wr),
    .mask_hi_wr_in(mask_hi_wr),
    .wr_data_in(wr_data_in),
    .pend_out(pend),
    .mask_out(mask),
    .irq_out(irq_out)
  );

  // unmapped addresses read zero
  always_comb begin
    next_rd_data = cais_pkg::RST_REG8;
    if (addr_in == cais_pkg::ADDR_GLOBAL_IRQ) begin
      next_rd_data[cais_pkg::GIE_BIT] = global_irq_enable;
    end else if (addr_in == cais_pkg::ADDR_VIOL_MODE) begin
      next_rd_data[cais_pkg::VIOL_MODE_BIT] = viol_mode;
    end else if (addr_in == cais_pkg::ADDR_PEND_LO) begin
      next_rd_data = pend[cais_pkg::LO_CH-1:0];
    end else if (addr_in == cais_pkg::ADDR_PEND_HI) begin
      next_rd_data[cais_pkg::HI_CH-1:0] =
        pend[cais_pkg::NUM_CH-1:cais_pkg::LO_CH];
    end else if (addr_in == cais_pkg::ADDR_MASK_LO) begin
      next_rd_data = mask[cais_pkg::LO_CH-1:0];
    end else if (addr_in == cais_pkg::ADDR_MASK_HI) begin
      next_rd_data[cais_pkg::HI_CH-1:0] =
        mask[cais_pkg::NUM_CH-1:cais_pkg::LO_CH];
    end else if (ch_hit && sub_field == cais_pkg::OFF_ENABLE) begin
      next_rd_data = enable_reg[ch_field];
    end else if (ch_hit && sub_field == cais_pkg::OFF_ALARM) begin
      next_rd_data = alarm_state[ch_field]; // [R8]
    end else if (ch_hit && sub_field == cais_pkg::OFF_CHANGE) begin
      next_rd_data = change_latch[ch_field]; // value before the clear
    end
  end

  // data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rd_data_out <= cais_pkg::RST_REG8;
    end else if (ce_in) begin
      rd_data_out <= rd_in ? next_rd_data : cais_pkg::RST_REG8;
    end
  end
endmodule

/* rtl/cais_pkg.sv */
/*
  Constants for the per-channel alarm and change-of-status block:
  register offsets, bit positions and reset values.
  Assumes an 8-bit register port with an 8-bit byte address.
*/
package cais_pkg;
  localparam int NUM_CH = 14;
  localparam int IDX_W = 4;
  localparam logic [3:0] CH_FIELD_MAX = 4'hd;

  // per-channel sub-offsets; channel n sits at 16*n plus these
  localparam logic [3:0] OFF_ENABLE = 4'h4;
  localparam logic [3:0] OFF_ALARM = 4'h5;
  localparam logic [3:0] OFF_CHANGE = 4'h6;

  // global registers
  localparam logic [7:0] ADDR_GLOBAL_IRQ = 8'he0;
  localparam logic [7:0] ADDR_VIOL_MODE = 8'he5;
  localparam int GIE_BIT = 0;
  localparam int VIOL_MODE_BIT = 7;

  // channel summary status and mask, split over low and high bytes
  localparam logic [7:0] ADDR_PEND_LO = 8'hf0;
  localparam logic [7:0] ADDR_PEND_HI = 8'hf1;
  localparam logic [7:0] ADDR_MASK_LO = 8'hf2;
  localparam logic [7:0] ADDR_MASK_HI = 8'hf3;
  localparam int LO_CH = 8;
  localparam int HI_CH = NUM_CH - LO_CH;

  // alarm and change bit positions
  localparam int BIT_DRIVER = 6;
  localparam int BIT_FIFO = 5;
  localparam int BIT_VIOL = 4;
  localparam int BIT_ONES = 2;
  localparam int BIT_LOST = 1;
  localparam int BIT_PATTERN = 0;

  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [NUM_CH-1:0] RST_PEND = 14'h0000;
  localparam logic [NUM_CH-1:0] RST_MASK = 14'h3fff;
endpackage

/* rtl/cais_channel.sv */
/*
  One channel: live alarm register, change-of-status latch with
  clear on read, and the channel interrupt enable register.
  Assumes alarm inputs are synchronous levels on clk_in.
*/
`timescale 1ns/1ps
module cais_channel (
  input wire logic clk_in, // system clock
  input wire logic sys_rst_in, // sync reset, active high
  input wire logic ce_in, // clock enable
  input wire logic driver_fault_alarm_in, // tx driver failure
  input wire logic fifo_pointer_near_alarm_in, // fifo pointers close
  input wire logic violation_in, // line violation activity
  input wire logic overflow_in, // violation counter overflow
  input wire logic all_ones_alarm_in, // all-ones detected
  input wire logic receive_signal_lost_in, // loss of signal
  input wire logic test_pattern_locked_in, // pattern detector lock
  input wire logic overflow_mode_in, // 1: report counter overflow
  input wire logic enable_wr_in, // write enable register
  input wire logic [7:0] wr_data_in, // write data
  input wire logic change_rd_in, // change latch being read
  output logic [7:0] alarm_state_out, // live alarm register
  output logic [7:0] change_latch_out, // change-of-status latch
  output logic [7:0] enable_out, // interrupt enable register
  output logic req_out // enabled change pending
);
  logic [7:0] next_alarm;

  always_comb begin
    next_alarm = cais_pkg::RST_REG8; // reserved d7, d3 stay zero [R11]
    next_alarm[cais_pkg::BIT_DRIVER] = driver_fault_alarm_in; // [R1]
    next_alarm[cais_pkg::BIT_FIFO] = fifo_pointer_near_alarm_in; // [R2]
    next_alarm[cais_pkg::BIT_VIOL] = overflow_mode_in ? overflow_in :
                                     violation_in; // [R3] [R4]
    next_alarm[cais_pkg::BIT_ONES] = all_ones_alarm_in; // [R5]
    next_alarm[cais_pkg::BIT_LOST] = receive_signal_lost_in; // [R6]
    next_alarm[cais_pkg::BIT_PATTERN] = test_pattern_locked_in; // [R7]
  end

  // tracks conditions whatever the enables say [R8]
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      alarm_state_out <= cais_pkg::RST_REG8;
    end else if (ce_in) begin
      alarm_state_out <= next_alarm;
    end
  end

  // a change in the read cycle survives the clear: set wins
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      change_latch_out <= cais_pkg::RST_REG8;
    end else if (ce_in) begin
      change_latch_out <= (change_latch_out & ~{8{change_rd_in}}) |
                          (alarm_state_out ^ next_alarm); // [R10] [R12] [R13]
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      enable_out <= cais_pkg::RST_REG8;
    end else if (ce_in && enable_wr_in) begin
      enable_out <= wr_data_in;
    end
  end

  assign req_out = |(change_latch_out & enable_out); // [R9] [R14]
endmodule

/* rtl/cais_irq.sv */
/*
  Channel summary: sticky per-channel pending bits (write one to
  clear), a mask of the same layout and the level interrupt.
  Assumes channel requests are synchronous levels.
*/
`timescale 1ns/1ps
module cais_irq (
  input wire logic clk_in, // system clock
  input wire logic sys_rst_in, // sync reset, active high
  input wire logic ce_in, // clock enable
  input wire logic [cais_pkg::NUM_CH-1:0] ch_req_in, // channel requests
  input wire logic global_irq_enable_in, // global enable
  input wire logic [cais_pkg::NUM_CH-1:0] pend_clr_in, // w1c bits
  input wire logic mask_lo_wr_in, // write mask low byte
  input wire logic mask_hi_wr_in, // write mask high byte
  input wire logic [7:0] wr_data_in, // write data
  output logic [cais_pkg::NUM_CH-1:0] pend_out, // pending bits
  output logic [cais_pkg::NUM_CH-1:0] mask_out, // mask bits
  output logic irq_out // level interrupt, active high
);
  // set wins over a clear in the same cycle, so a held request
  // keeps its bit until the channel latch itself is read clear
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pend_out <= cais_pkg::RST_PEND;
    end else if (ce_in) begin
      pend_out <= (pend_out & ~pend_clr_in) | ch_req_in; // [R16]
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mask_out <= cais_pkg::RST_MASK;
    end else if (ce_in) begin
      if (mask_lo_wr_in) begin
        mask_out[cais_pkg::LO_CH-1:0] <= wr_data_in;
      end
      if (mask_hi_wr_in) begin
        mask_out[cais_pkg::NUM_CH-1:cais_pkg::LO_CH] <=
          wr_data_in[cais_pkg::HI_CH-1:0];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      irq_out <= 1'b0;
    end else if (ce_in) begin
      irq_out <= global_irq_enable_in &
                 (|(pend_out & mask_out)); // [R9] [R14] [R16]
    end
  end
endmodule

/* tb/cais_top_asserts.sv */
/* port-level checks for the alarm and change-of-status block.
   assumes one clock domain; bound to every cais_top. */
`timescale 1ns/1ps
module cais_checker (
  input wire logic clk_in, // clock
  input wire logic sys_rst_in, // reset
  input wire logic ce_in, // enable
  input wire logic [7:0] addr_in, // address
  input wire logic [7:0] wr_data_in, // data
  input wire logic wr_in, // write
  input wire logic rd_in, // read
  input wire logic [cais_pkg::NUM_CH-1:0] driver_fault_alarm_in, // a
  input wire logic [cais_pkg::NUM_CH-1:0] fifo_pointer_near_alarm_in, // a
  input wire logic [cais_pkg::NUM_CH-1:0] violation_in, // a
  input wire logic [cais_pkg::NUM_CH-1:0] overflow_in, // a
  input wire logic [cais_pkg::NUM_CH-1:0] all_ones_alarm_in, // a
  input wire logic [cais_pkg::NUM_CH-1:0] receive_signal_lost_in, // a
  input wire logic [cais_pkg::NUM_CH-1:0] test_pattern_locked_in, // a
  input wire logic [7:0] rd_data_out, // read data
  input wire logic irq_out // interrupt
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [6:0] ch0_v;
  logic [6:0] ch0_d1;
  logic [6:0] ch0_d2;
  logic rd_chg;
  assign ch0_v = {driver_fault_alarm_in[0], fifo_pointer_near_alarm_in[0],
    violation_in[0], overflow_in[0], all_ones_alarm_in[0],
    receive_signal_lost_in[0], test_pattern_locked_in[0]};
  assign rd_chg = ce_in && rd_in && addr_in == 8'h06;
  // inputs two edges back, what a read of channel 0 must show
  always_ff @(posedge clk_in) begin
    ch0_d1 <= ch0_v;
    ch0_d2 <= ch0_d1;
  end
  a_alarm_live: assert property (ce_in && rd_in && addr_in == 8'h05 &&
    $past(ce_in) && !$past(sys_rst_in) |=> rd_data_out[7:5] ==
    {1'b0, ch0_d2[6:5]} && rd_data_out[3:0] == {1'b0, ch0_d2[2:0]})
    else $error("alarm state read mismatch");
  a_read_quiet: assert property (ce_in && !rd_in |=> rd_data_out == 8'h00)
    else $error("read data outside read slot");
  a_reserved_zero: assert property (ce_in && rd_in && addr_in[3:0] == 4'h6
    |=> !rd_data_out[7] && !rd_data_out[3]) else $error("reserved bit set");
  a_read_clears: assert property (rd_chg && $stable(ch0_v) && !$past(wr_in)
    && $past(ce_in) && !$past(sys_rst_in) ##1 rd_chg |=> rd_data_out == 8'h00)
    else $error("change latch not cleared by read");
  a_driver_change: assert property ($changed(driver_fault_alarm_in[0]) &&
    ce_in && $past(ce_in) && !$past(sys_rst_in) ##1 rd_chg |=> rd_data_out[6])
    else $error("driver change not latched");
  a_lost_change: assert property ($changed(receive_signal_lost_in[0]) &&
    ce_in && $past(ce_in) && !$past(sys_rst_in) ##1 rd_chg |=> rd_data_out[1])
    else $error("signal lost change not latched");
  a_enable_stored: assert property (ce_in && wr_in && addr_in[3:0] == 4'h4
    && addr_in[7:4] <= 4'hd ##1 !wr_in ##1 ce_in && rd_in && addr_in ==
    $past(addr_in, 2) |=> rd_data_out == $past(wr_data_in, 3))
    else $error("enable register readback mismatch");
  // a write acts on irq_out two edges later, so look back one cycle too
  a_irq_holds: assert property (irq_out && !wr_in && !$past(wr_in)
    |=> irq_out) else $error("interrupt dropped without a write");
  a_freeze_hold: assert property (!ce_in |=> $stable(rd_data_out) &&
    $stable(irq_out)) else $error("outputs moved with clock enable low");
  cover property ($rose(irq_out));
  cover property (rd_chg ##1 rd_data_out != 8'h00);
  cover property (ce_in && wr_in && addr_in == 8'he5);
endmodule
bind cais_top cais_checker chk_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .ce_in(ce_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
  .rd_in(rd_in), .driver_fault_alarm_in(driver_fault_alarm_in),
  .fifo_pointer_near_alarm_in(fifo_pointer_near_alarm_in),
  .violation_in(violation_in), .overflow_in(overflow_in),
  .all_ones_alarm_in(all_ones_alarm_in),
  .receive_signal_lost_in(receive_signal_lost_in),
  .test_pattern_locked_in(test_pattern_locked_in),
  .rd_data_out(rd_data_out), .irq_out(irq_out));

/* tb/cais_top_tb.sv */
/* self-checking bench: random alarm traffic, register sweeps and
   interrupt gating; drives the cais_top ports directly. */
`timescale 1ns/1ps
module cais_top_tb;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic ce_in = 1'b1;
  logic irq_out;
  logic mode = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wr_data_in = 8'h00;
  logic [7:0] rd_data_out;
  logic [7:0] d1;
  logic [7:0] last [0:13];
  logic [13:0] in_v [0:6];
  logic [31:0] r;
  int seed = 33072;
  int fail_count = 0;
  int checks_done = 0;
  int ch;
  int i;
  int b;
  cais_top dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
    .driver_fault_alarm_in(in_v[6]), .fifo_pointer_near_alarm_in(in_v[5]),
    .violation_in(in_v[3]), .overflow_in(in_v[4]),
    .all_ones_alarm_in(in_v[2]), .receive_signal_lost_in(in_v[1]),
    .test_pattern_locked_in(in_v[0]), .rd_data_out(rd_data_out),
    .irq_out(irq_out));
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  function automatic logic [7:0] exp_alarm(int c);
    return {1'b0, in_v[6][c], in_v[5][c], mode ? in_v[4][c] : in_v[3][c],
      1'b0, in_v[2][c], in_v[1][c], in_v[0][c]};
  endfunction
  task automatic check(logic [7:0] got, logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // two back-to-back reads of one address; second result checked zero
  // only where the caller knows it must be
  task automatic rd2(logic [7:0] a, logic zero2);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    #1 d1 = rd_data_out;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 if (zero2) check(rd_data_out, 8'h00);
  endtask
  task automatic chk_ch(int c);
    rd2({c[3:0], 4'h6}, 1'b1);
    check(d1, exp_alarm(c) ^ last[c]);
    last[c] = exp_alarm(c);
    rd2({c[3:0], 4'h5}, 1'b0);
    check(d1, exp_alarm(c));
  endtask
  task automatic end_sim;
    if (fail_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // whole run is about 1300 cycles
  initial begin
    #400000;
    fail_count++;
    end_sim;
  end
  initial begin
    for (i = 0; i < 14; i++) last[i] = 8'h00;
    for (i = 0; i < 7; i++) in_v[i] = 14'h0000;
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      wr(8'he5, {m[0], 7'h00});
      mode = m[0];
      for (ch = 0; ch < 14; ch++) begin
        wr({ch[3:0], 4'h5}, 8'hff);
        chk_ch(ch);
        r = $random(seed);
        wr({ch[3:0], 4'h4}, r[7:0]);
        rd2({ch[3:0], 4'h4}, 1'b0);
        check(d1, r[7:0]);
        wr({ch[3:0], 4'h4}, 8'h00);
        rd2({ch[3:0], 4'h7}, 1'b0);
        check(d1, 8'h00);
      end
      for (i = 0; i < 40; i++) begin
        r = $random(seed);
        ch = (i % 2 == 0) ? 0 : r[11:8] % 14;
        @(posedge clk_in);
        for (b = 0; b < 7; b++) in_v[b][ch] <= r[b];
        chk_ch(ch);
      end
    end
    // mode stays on overflow here, so input index equals bit position
    for (b = 0; b < 7; b++) begin
      if (b == 3) continue;
      wr(8'h54, 8'h01 << b);
      wr(8'he0, 8'h00);
      @(posedge clk_in);
      in_v[b][5] <= ~in_v[b][5];
      repeat (4) @(posedge clk_in);
      #1 check({7'h00, irq_out}, 8'h00);
      wr(8'he0, 8'h01);
      repeat (3) @(posedge clk_in);
      #1 check({7'h00, irq_out}, 8'h01);
      wr(8'hf2, 8'hdf);
      repeat (3) @(posedge clk_in);
      #1 check({7'h00, irq_out}, 8'h00);
      wr(8'hf2, 8'hff);
      rd2(8'hf0, 1'b0);
      check(d1, 8'h20);
      chk_ch(5);
      #1 check({7'h00, irq_out}, 8'h01);
      wr(8'hf0, 8'h20);
      repeat (3) @(posedge clk_in);
      #1 check({7'h00, irq_out}, 8'h00);
    end
    // global registers and the untouched high mask byte read back
    rd2(8'he0, 1'b0);
    check(d1, 8'h01);
    rd2(8'he5, 1'b0);
    check(d1, 8'h80);
    rd2(8'hf3, 1'b0);
    check(d1, 8'h3f);
    // a write with clock enable low must be lost
    @(posedge clk_in);
    ce_in <= 1'b0;
    wr(8'h04, 8'h5a);
    @(posedge clk_in);
    ce_in <= 1'b1;
    rd2(8'h04, 1'b0);
    check(d1, 8'h00);
    end_sim;
  end
endmodule
